/* rtl/ufc_fifo_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module ufc_fifo_ctl import ufc_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [REG_AW-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Receive data from MAC
	input wire logic i_rx_valid,
	input wire logic [31:0] i_rx_data,
	output logic o_rx_ready,
	input wire logic i_mac_receive_reg_busy,
	// Receive data towards USB
	output logic o_rxo_valid,
	output logic [31:0] o_rxo_data,
	input wire logic i_rxo_ready,
	// Transmit data from bulk-out receiver
	input wire logic i_tx_valid,
	input wire logic [31:0] i_tx_data,
	output logic o_tx_ready,
	// Transmit FIFO read side
	output logic o_txf_valid,
	output logic [31:0] o_txf_data,
	input wire logic i_txf_ready,
	// Sideband to MAC
	output logic o_mac_receive_reg_en,
	output logic o_fc_on,
	output logic o_fc_off,
	output logic o_pause_xoff,
	output logic o_pause_xon,
	output logic o_cs_igmp,
	output logic o_cs_icmp,
	output logic o_cs_ip,
	output logic o_cs_l4,
	output logic o_lso,
	output logic o_tag_ins,
	output logic o_tag_rep,
	output logic o_fcs_ins,
	output logic [CB_MSS_W-1:0] o_mss,
	output logic [15:0] o_vtag,
	// Events towards interrupt endpoint
	output logic o_rx_dis_irq,
	output logic o_tx_err
);
	// ****************************************
	// Register decode
	// ****************************************
	wire logic wr_rxc = i_wr & (i_addr == OFF_RX_CTL);
	wire logic wr_mac = i_wr & (i_addr == OFF_MAC_RECEIVE_REG);
	wire logic wr_int = i_wr & (i_addr == OFF_INTERRUPT_STATUS_REG);
	wire logic wr_ien = i_wr & (i_addr == OFF_INT_EN);
	wire logic wr_thr = i_wr & (i_addr == OFF_FLOW_THR);
	wire logic wr_fct = i_wr & (i_addr == OFF_FLOW_CTL);

	logic flush_r;
	logic fifo_en_r;
	logic fct_dis_r;
	logic fct_done_r;
	logic mac_en_r;
	logic mac_dis_r;
	logic mac_done_r;
	logic irq_en_r;
	logic tx_err_r;
	logic pause_en_r;
	logic [RX_LW-1:0] on_thr_r;
	logic [RX_LW-1:0] off_thr_r;

	// ****************************************
	// Receive FIFO
	// ****************************************
	logic [31:0] rx_mem [RX_DEPTH];
	logic [RX_AW-1:0] rx_wp_r;
	logic [RX_AW-1:0] rx_rp_r;
	logic [RX_LW-1:0] rx_cnt_r;
	wire logic rx_full = rx_cnt_r == RX_LW'(RX_DEPTH);
	wire logic rx_empty = rx_cnt_r == '0;
	// Writes blocked during flush so nothing lands after the pointers reset
	assign o_rx_ready = fifo_en_r & ~flush_r & ~rx_full;
	wire logic rx_push = i_rx_valid & o_rx_ready;
	wire logic rx_pop = i_rxo_ready & ~rx_empty & ~flush_r;
	assign o_rxo_valid = ~rx_empty & ~flush_r;
	assign o_rxo_data = rx_mem[rx_rp_r];

	always_ff @(posedge i_clk) begin
		if (rx_push)
			rx_mem[rx_wp_r] <= i_rx_data;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			rx_cnt_r <= '0;
		end else if (flush_r) begin
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			rx_cnt_r <= '0;
		end else begin
			rx_wp_r <= rx_wp_r + RX_AW'(rx_push);
			rx_rp_r <= rx_rp_r + RX_AW'(rx_pop);
			rx_cnt_r <= rx_cnt_r + RX_LW'(rx_push) - RX_LW'(rx_pop);
		end
	end

	// ****************************************
	// Receive control and status
	// ****************************************
	// Each halt completes once no frame is in flight on its own side (i_mac_receive_reg_busy for MAC, i_rx_valid for FIFO)
	wire logic mac_halt = ~mac_en_r & ~i_mac_receive_reg_busy & ~mac_done_r;
	wire logic fct_halt = ~fifo_en_r & ~i_rx_valid & ~fct_done_r;
	wire logic clr_fct_dis = wr_rxc & i_wdata[RXC_DIS_BIT];
	wire logic clr_mac_dis = wr_mac & i_wdata[MACRX_DIS_BIT];

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flush_r <= 1'b0;
			fifo_en_r <= 1'b0;
			fct_dis_r <= 1'b0;
			fct_done_r <= 1'b0;
			mac_en_r <= 1'b0;
			mac_dis_r <= 1'b0;
			mac_done_r <= 1'b0;
			irq_en_r <= INT_EN_RST;
			pause_en_r <= 1'b0;
			on_thr_r <= FLOW_THR_RST[THR_ON_LSB +: RX_LW];
			off_thr_r <= FLOW_THR_RST[THR_OFF_LSB +: RX_LW];
		end else begin
			// Flush takes one cycle, then the bit drops by itself
			if (flush_r)
				flush_r <= 1'b0;
			else if (wr_rxc)
				flush_r <= i_wdata[RXC_FLUSH_BIT];
			if (wr_rxc)
				fifo_en_r <= i_wdata[RXC_EN_BIT];
			if (wr_mac)
				mac_en_r <= i_wdata[MACRX_EN_BIT];
			if (fifo_en_r)
				fct_done_r <= 1'b0;
			else if (fct_halt)
				fct_done_r <= 1'b1;
			if (mac_en_r)
				mac_done_r <= 1'b0;
			else if (mac_halt)
				mac_done_r <= 1'b1;
			// Set beats a same-cycle clear
			if (fct_halt)
				fct_dis_r <= 1'b1;
			else if (clr_fct_dis)
				fct_dis_r <= 1'b0;
			if (mac_halt)
				mac_dis_r <= 1'b1;
			else if (clr_mac_dis)
				mac_dis_r <= 1'b0;
			if (wr_ien)
				irq_en_r <= i_wdata[INT_RXDIS_BIT];
			if (wr_fct)
				pause_en_r <= i_wdata[0];
			if (wr_thr) begin
				on_thr_r <= i_wdata[THR_ON_LSB +: RX_LW];
				off_thr_r <= i_wdata[THR_OFF_LSB +: RX_LW];
			end
		end
	end

	assign o_mac_receive_reg_en = mac_en_r;
	// Held until software clears both status bits
	wire logic rx_dis_evt = irq_en_r & (fct_dis_r | mac_dis_r);

	ufc_flow_ctl u_flow (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_level(rx_cnt_r),
		.i_on_thr(on_thr_r),
		.i_off_thr(off_thr_r),
		.i_pause_en(pause_en_r),
		.o_fc_on(o_fc_on),
		.o_fc_off(o_fc_off),
		.o_pause_xoff(o_pause_xoff),
		.o_pause_xon(o_pause_xon)
	);

	// ****************************************
	// Transmit FIFO write side
	// ****************************************
	logic [31:0] tx_mem [TX_DEPTH];
	logic [TX_AW-1:0] tx_wp_r;
	logic [TX_AW-1:0] tx_rp_r;
	logic [TX_AW:0] tx_cnt_r;
	ufc_txw_e txw_r;
	logic [17:0] words_left_r;
	logic [CA_LEN_W-1:0] len_r;
	wire logic tx_full = tx_cnt_r == TX_FULL_CNT;
	wire logic tx_empty = tx_cnt_r == '0;

	logic d_igmp, d_icmp, d_lso, d_ip, d_l4, d_ins, d_rep, d_fcs, d_err;
	logic [CA_LEN_W-1:0] d_len;
	ufc_txcmd_dec u_dec (
		.i_cmd_a(i_tx_data),
		.o_igmp(d_igmp),
		.o_icmp(d_icmp),
		.o_lso(d_lso),
		.o_ip(d_ip),
		.o_l4(d_l4),
		.o_tag_ins(d_ins),
		.o_tag_rep(d_rep),
		.o_fcs_ins(d_fcs),
		.o_len(d_len),
		.o_err(d_err)
	);

	// Length word costs one stall cycle while command A waits at the input
	assign o_tx_ready = ~tx_full & (txw_r != TXW_CMDA);
	wire logic tx_push = i_tx_valid & ~tx_full;
	wire logic tx_take = i_tx_valid & o_tx_ready;
	wire logic [31:0] tx_wword = (txw_r == TXW_CMDA) ? {12'h000, d_len} : i_tx_data;
	wire logic tx_pop = i_txf_ready & ~tx_empty;
	assign o_txf_valid = ~tx_empty;
	assign o_txf_data = tx_mem[tx_rp_r];

	always_ff @(posedge i_clk) begin
		if (tx_push)
			tx_mem[tx_wp_r] <= tx_wword;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_wp_r <= '0;
			tx_rp_r <= '0;
			tx_cnt_r <= '0;
		end else begin
			if (tx_push)
				tx_wp_r <= (tx_wp_r == TX_LAST) ? '0 : tx_wp_r + TX_AW'(1);
			if (tx_pop)
				tx_rp_r <= (tx_rp_r == TX_LAST) ? '0 : tx_rp_r + TX_AW'(1);
			tx_cnt_r <= tx_cnt_r + (TX_AW+1)'(tx_push) - (TX_AW+1)'(tx_pop);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			txw_r <= TXW_CMDA;
			words_left_r <= '0;
			len_r <= '0;
		end else begin
			unique case (txw_r)
				TXW_CMDA: begin
					if (tx_push)
						txw_r <= TXW_CMDA2;
				end
				TXW_CMDA2: begin
					if (tx_take) begin
						len_r <= d_len;
						txw_r <= TXW_CMDB;
					end
				end
				TXW_CMDB: begin
					if (tx_take) begin
						words_left_r <= ufc_len_words(len_r);
						txw_r <= (len_r == '0) ? TXW_CMDA : TXW_DATA;
					end
				end
				TXW_DATA: begin
					if (tx_take) begin
						words_left_r <= words_left_r - 18'h00001;
						if (words_left_r == 18'h00001)
							txw_r <= TXW_CMDA;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Captured command fields and error flag
	// ****************************************
	wire logic cap_a = tx_take & (txw_r == TXW_CMDA2);
	wire logic cap_b = tx_take & (txw_r == TXW_CMDB);
	wire logic clr_tx_err = wr_int & i_wdata[INT_TXERR_BIT];

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{o_cs_igmp, o_cs_icmp, o_cs_ip, o_cs_l4} <= 4'h0;
			{o_lso, o_tag_ins, o_tag_rep, o_fcs_ins} <= 4'h0;
			o_mss <= '0;
			o_vtag <= 16'h0000;
			tx_err_r <= 1'b0;
		end else begin
			if (cap_a) begin
				{o_cs_igmp, o_cs_icmp} <= {d_igmp, d_icmp};
				{o_cs_ip, o_cs_l4} <= {d_ip, d_l4};
				o_lso <= d_lso;
				{o_tag_ins, o_tag_rep} <= {d_ins, d_rep};
				o_fcs_ins <= d_fcs;
			end
			if (cap_b) begin
				o_mss <= i_tx_data[CB_MSS_LSB +: CB_MSS_W];
				o_vtag <= i_tx_data[15:0];
			end
			if (cap_a & d_err)
				tx_err_r <= 1'b1;
			else if (clr_tx_err)
				tx_err_r <= 1'b0;
		end
	end

	assign o_tx_err = tx_err_r;
	assign o_rx_dis_irq = rx_dis_evt;

	// ****************************************
	// Register read
	// ****************************************
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (i_addr)
			OFF_RX_CTL: begin
				rd_mux[RXC_FLUSH_BIT] = flush_r;
				rd_mux[RXC_EN_BIT] = fifo_en_r;
				rd_mux[RXC_DIS_BIT] = fct_dis_r;
				rd_mux[8 +: RX_LW] = rx_cnt_r;
			end
			OFF_MAC_RECEIVE_REG: begin
				rd_mux[MACRX_EN_BIT] = mac_en_r;
				rd_mux[MACRX_DIS_BIT] = mac_dis_r;
			end
			OFF_INTERRUPT_STATUS_REG: begin
				rd_mux[INT_RXDIS_BIT] = rx_dis_evt;
				rd_mux[INT_TXERR_BIT] = tx_err_r;
			end
			OFF_INT_EN: rd_mux[INT_RXDIS_BIT] = irq_en_r;
			OFF_FLOW_THR: begin
				rd_mux[THR_ON_LSB +: RX_LW] = on_thr_r;
				rd_mux[THR_OFF_LSB +: RX_LW] = off_thr_r;
			end
			OFF_FLOW_CTL: rd_mux[0] = pause_en_r;
			OFF_TX_STS: rd_mux[TX_AW:0] = tx_cnt_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_rdata <= 32'h0000_0000;
		else if (i_rd)
			o_rdata <= rd_mux;
		else
			o_rdata <= 32'h0000_0000;
	end
endmodule
`default_nettype wire

/* rtl/ufc_flow_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_ctl import ufc_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Level and settings
	input wire logic [RX_LW-1:0] i_level,
	input wire logic [RX_LW-1:0] i_on_thr,
	input wire logic [RX_LW-1:0] i_off_thr,
	input wire logic i_pause_en,
	// To MAC
	output logic o_fc_on,
	output logic o_fc_off,
	output logic o_pause_xoff,
	output logic o_pause_xon
);
	logic paused_r;
	wire logic over = i_level > i_on_thr;
	wire logic under = i_level < i_off_thr;
	// Off only once level has left the on band, so both never show together
	wire logic go_off = paused_r & under & ~over;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			paused_r <= 1'b0;
			o_fc_on <= 1'b0;
			o_fc_off <= 1'b0;
			o_pause_xoff <= 1'b0;
			o_pause_xon <= 1'b0;
		end else begin
			o_fc_on <= over;
			o_fc_off <= go_off;
			o_pause_xoff <= i_pause_en & over & ~paused_r;
			o_pause_xon <= i_pause_en & go_off;
			if (over)
				paused_r <= 1'b1;
			else if (go_off)
				paused_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* rtl/ufc_pkg.sv */
// Operation
// - A receive FIFO flush returns both receive pointers to reset, dropping content
// - Setting the flush bit starts the flush; hardware clears it when done
// - Receive-disabled interrupt holds until both disabled status bits are cleared
// - Receive-disabled interrupt shows in interrupt status and goes to interrupt endpoint
// - Clearing receiver enable halts reception; halt sets disabled status and interrupt
// - Flow-control-on asserts while receive FIFO level exceeds the on-threshold
// - Flow-control-off asserts when level later falls below the off-threshold
// - Pause frame request on flow-control-on only when pause transmit is enabled
// - Zero-time pause request on flow-control-off, gated by the same enable
// - Transmit FIFO of 12 KB buffers bulk-out data for frame extraction
// - Transmit write side stores valid data unmodified, no rewind support
// - A 32-bit frame length word is written ahead of the command words
// - Command A bits 29 and 28 request IGMP and ICMP checksums, ignored under SEGMENTATION_OFFLOAD_ENABLE
// - Command A bits 26 and 25 request IP and TCP/UDP checksums, ignored under SEGMENTATION_OFFLOAD_ENABLE
// - Command A bit 27 enables segmentation offload using command B segment size
// - Bit 24 inserts a tag; bit 23 replaces an existing tag instead
// - Bit 22 appends FCS and zero-pads short frames; clear means never pad
// - Command A bits 19 to 0 carry the frame length
// - Transmitter error when reserved bits set or replace set without insert
package ufc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int REG_AW = 5;
	localparam logic [4:0] OFF_RX_CTL = 5'h00;
	localparam logic [4:0] OFF_MAC_RECEIVE_REG = 5'h04;
	localparam logic [4:0] OFF_INTERRUPT_STATUS_REG = 5'h08;
	localparam logic [4:0] OFF_INT_EN = 5'h0C;
	localparam logic [4:0] OFF_FLOW_THR = 5'h10;
	localparam logic [4:0] OFF_FLOW_CTL = 5'h14;
	localparam logic [4:0] OFF_TX_STS = 5'h18;
	localparam int RXC_FLUSH_BIT = 0;
	localparam int RXC_EN_BIT = 1;
	localparam int RXC_DIS_BIT = 2;
	localparam int MACRX_EN_BIT = 0;
	localparam int MACRX_DIS_BIT = 1;
	localparam int INT_RXDIS_BIT = 0;
	localparam int INT_TXERR_BIT = 1;
	localparam int THR_ON_LSB = 0;
	localparam int THR_OFF_LSB = 16;
	localparam logic [31:0] FLOW_THR_RST = 32'h0000_0000;
	localparam logic INT_EN_RST = 1'b0;
	// ****************************************
	// FIFO geometry
	// ****************************************
	localparam int RX_DEPTH = 64;
	localparam int RX_AW = 6;
	localparam int RX_LW = 7;
	localparam int TX_BYTES = 12288;
	localparam int TX_DEPTH = TX_BYTES / 4;
	localparam int TX_AW = 12;
	localparam logic [TX_AW-1:0] TX_LAST = 12'hBFF;
	localparam logic [TX_AW:0] TX_FULL_CNT = 13'h0C00;
	// ****************************************
	// Command A and B layout
	// ****************************************
	localparam int CA_IGMP = 29;
	localparam int CA_ICMP = 28;
	localparam int CA_LSO = 27;
	localparam int CA_IP = 26;
	localparam int CA_L4 = 25;
	localparam int CA_TAG_INS = 24;
	localparam int CA_TAG_REP = 23;
	localparam int CA_FCS = 22;
	localparam int CA_LEN_W = 20;
	localparam int CB_MSS_LSB = 16;
	localparam int CB_MSS_W = 14;

	typedef enum logic [1:0] {TXW_CMDA, TXW_CMDA2, TXW_CMDB, TXW_DATA} ufc_txw_e;

	// Whole 32-bit words needed for a byte length
	function automatic logic [17:0] ufc_len_words(input logic [CA_LEN_W-1:0] len);
		ufc_len_words = 18'(len >> 2) + 18'(|len[1:0]);
	endfunction
endpackage

/* rtl/ufc_txcmd_dec.sv */
`timescale 1ns/1ps
`default_nettype none
module ufc_txcmd_dec import ufc_pkg::*; (
	// Command word
	input wire logic [31:0] i_cmd_a,
	// Decoded fields
	output logic o_igmp,
	output logic o_icmp,
	output logic o_lso,
	output logic o_ip,
	output logic o_l4,
	output logic o_tag_ins,
	output logic o_tag_rep,
	output logic o_fcs_ins,
	output logic [CA_LEN_W-1:0] o_len,
	output logic o_err
);
	assign o_lso = i_cmd_a[CA_LSO];
	// Checksum requests have no meaning under segmentation offload
	assign o_igmp = i_cmd_a[CA_IGMP] & ~o_lso;
	assign o_icmp = i_cmd_a[CA_ICMP] & ~o_lso;
	assign o_ip = i_cmd_a[CA_IP] & ~o_lso;
	assign o_l4 = i_cmd_a[CA_L4] & ~o_lso;
	assign o_tag_ins = i_cmd_a[CA_TAG_INS];
	assign o_tag_rep = i_cmd_a[CA_TAG_REP] & o_tag_ins;
	assign o_fcs_ins = i_cmd_a[CA_FCS];
	assign o_len = i_cmd_a[CA_LEN_W-1:0];
	assign o_err = (|i_cmd_a[31:30]) | (|i_cmd_a[21:20])
		| (i_cmd_a[CA_TAG_REP] & ~i_cmd_a[CA_TAG_INS]);
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import ufc_pkg::*;;
	localparam int LIMIT = 20000;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [REG_AW-1:0] i_addr = 5'h00;
	logic [31:0] i_wdata = 32'h0, i_tx_data = 32'h0, o_rdata, o_rxo_data, o_txf_data, i_rx_data;
	logic i_wr = 1'b0, i_rd = 1'b0, i_tx_valid = 1'b0, i_rxo_ready = 1'b0, go = 1'b0, slow = 1'b0;
	logic o_rx_ready, i_rx_valid, i_mac_receive_reg_busy, o_rxo_valid, o_tx_ready, o_txf_valid, i_txf_ready;
	logic o_mac_receive_reg_en, o_fc_on, o_fc_off, o_pause_xoff, o_pause_xon, o_cs_igmp, o_cs_icmp, o_cs_ip, o_cs_l4;
	logic o_lso, o_tag_ins, o_tag_rep, o_fcs_ins, o_rx_dis_irq, o_tx_err;
	logic [CB_MSS_W-1:0] o_mss;
	logic [15:0] o_vtag;
	int error_cnt = 0, check_count = 0, cyc = 0;
	logic [31:0] rd_q[$], rx_q[$], tx_q[$];
	logic rd_d = 1'b0, seen_xoff = 1'b0, seen_xon = 1'b0, seen_off = 1'b0;
	logic [16:0] rnd = 17'h10075;
	logic [31:0] bad[5] = '{32'h0080_0000, 32'h4000_0000, 32'h8000_0000, 32'h0010_0000, 32'h0020_0000};

	always #2.5 i_clk = ~i_clk;

	ufc_fifo_ctl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
		.i_mac_receive_reg_busy(i_mac_receive_reg_busy), .o_rxo_valid(o_rxo_valid), .o_rxo_data(o_rxo_data),
		.i_rxo_ready(i_rxo_ready), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
		.o_txf_valid(o_txf_valid), .o_txf_data(o_txf_data), .i_txf_ready(i_txf_ready),
		.o_mac_receive_reg_en(o_mac_receive_reg_en), .o_fc_on(o_fc_on), .o_fc_off(o_fc_off), .o_pause_xoff(o_pause_xoff),
		.o_pause_xon(o_pause_xon), .o_cs_igmp(o_cs_igmp), .o_cs_icmp(o_cs_icmp), .o_cs_ip(o_cs_ip),
		.o_cs_l4(o_cs_l4), .o_lso(o_lso), .o_tag_ins(o_tag_ins), .o_tag_rep(o_tag_rep), .o_fcs_ins(o_fcs_ins),
		.o_mss(o_mss), .o_vtag(o_vtag), .o_rx_dis_irq(o_rx_dis_irq), .o_tx_err(o_tx_err));
	ufc_mac_model i_mac (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go), .i_slow(slow), .i_mac_receive_reg_en(o_mac_receive_reg_en),
		.i_rx_ready(o_rx_ready), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_busy(i_mac_receive_reg_busy),
		.o_txf_ready(i_txf_ready));

	function automatic logic [16:0] lfsr(input logic [16:0] x);
		lfsr = {x[15:0], x[16] ^ x[13]};
	endfunction
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// Bus and stream drivers
	// ****************************************
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(negedge i_clk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
	endtask
	task automatic tx_word(input logic [31:0] d);
		i_tx_valid <= 1'b1;
		i_tx_data <= d;
		@(posedge i_clk);
		while (!o_tx_ready) @(posedge i_clk);
	endtask
	task automatic tx_buf(input logic [31:0] a, input logic [31:0] b);
		int n;
		n = (int'(a[19:0]) + 3) / 4;
		tx_q.push_back({12'h000, a[19:0]});
		tx_q.push_back(a);
		tx_q.push_back(b);
		@(posedge i_clk);
		tx_word(a);
		tx_word(b);
		for (int k = 0; k < n; k++) begin
			rnd = lfsr(rnd);
			tx_q.push_back({rnd[15:0], ~rnd[15:0]});
			tx_word({rnd[15:0], ~rnd[15:0]});
		end
		i_tx_valid <= 1'b0;
		for (int k = 0; k < 200 && tx_q.size() > 0; k++) @(negedge i_clk);
	endtask
	// ****************************************
	// Result monitor
	// ****************************************
	always @(posedge i_clk) begin
		cyc++;
		if (rd_d)
			cmp("rdata", rd_q.pop_front(), o_rdata);
		rd_d <= i_rd;
		if (i_rx_valid && o_rx_ready)
			rx_q.push_back(i_rx_data);
		if (o_rxo_valid && i_rxo_ready)
			cmp("rx_out", rx_q.pop_front(), o_rxo_data);
		if (o_txf_valid && i_txf_ready)
			cmp("tx_out", tx_q.pop_front(), o_txf_data);
		if (o_pause_xoff) seen_xoff = 1'b1;
		if (o_pause_xon) seen_xon = 1'b1;
		if (o_fc_off) seen_off = 1'b1;
		if (cyc == LIMIT) begin
			error_cnt++;
			print_verdict;
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(negedge i_clk);
		rd(OFF_RX_CTL, 32'h4);
		rd(OFF_MAC_RECEIVE_REG, 32'h2);
		rd(OFF_FLOW_THR, FLOW_THR_RST);
		rd(5'h1C, 32'h0);
		wr(OFF_INT_EN, 32'h1);
		cmp("irq", 32'h1, 32'(o_rx_dis_irq));
		rd(OFF_INTERRUPT_STATUS_REG, 32'h1);
		wr(OFF_RX_CTL, 32'h4);
		cmp("irq", 32'h1, 32'(o_rx_dis_irq));
		wr(OFF_MAC_RECEIVE_REG, 32'h2);
		cmp("irq", 32'h0, 32'(o_rx_dis_irq));
		wr(OFF_MAC_RECEIVE_REG, 32'h1);
		wr(OFF_RX_CTL, 32'h2);
		cmp("mac_receive_reg_en", 32'h1, 32'(o_mac_receive_reg_en));
		go = 1'b1;
		repeat (6) @(negedge i_clk);
		go = 1'b0;
		repeat (3) @(negedge i_clk);
		wr(OFF_RX_CTL, 32'h3);
		rx_q.delete();
		rd(OFF_RX_CTL, 32'h2);
		cmp("rxo_valid", 32'h0, 32'(o_rxo_valid));
		wr(OFF_FLOW_THR, 32'h0004_0008);
		for (int pen = 1; pen >= 0; pen--) begin
			wr(OFF_FLOW_CTL, 32'(pen));
			seen_xoff = 1'b0;
			seen_xon = 1'b0;
			seen_off = 1'b0;
			go = 1'b1;
			for (int k = 0; k < 100 && !o_fc_on; k++) @(negedge i_clk);
			go = 1'b0;
			cmp("fc_on", 32'h1, 32'(o_fc_on));
			for (int k = 0; k < 300 && (o_rxo_valid || k < 4); k++) begin
				@(posedge i_clk);
				i_rxo_ready <= rnd[0];
				rnd = lfsr(rnd);
			end
			@(posedge i_clk);
			i_rxo_ready <= 1'b0;
			repeat (4) @(negedge i_clk);
			cmp("xoff", 32'(pen), 32'(seen_xoff));
			cmp("xon", 32'(pen), 32'(seen_xon));
			cmp("fc_off", 32'h1, 32'(seen_off));
			cmp("fc_on", 32'h0, 32'(o_fc_on));
		end
		go = 1'b1;
		wr(OFF_MAC_RECEIVE_REG, 32'h0);
		for (int k = 0; k < 50 && !o_rx_dis_irq; k++) @(negedge i_clk);
		go = 1'b0;
		cmp("irq", 32'h1, 32'(o_rx_dis_irq));
		rd(OFF_MAC_RECEIVE_REG, 32'h2);
		wr(OFF_RX_CTL, 32'h3);
		rx_q.delete();
		wr(OFF_MAC_RECEIVE_REG, 32'h1);
		wr(OFF_MAC_RECEIVE_REG, 32'h3);
		cmp("irq", 32'h0, 32'(o_rx_dis_irq));
		slow = 1'b1;
		tx_buf(32'h2D40_000A, 32'h0100_ABCD);
		cmp("lso_cs", 32'h0, {30'h0, o_cs_igmp, o_cs_ip});
		cmp("lso_mss", 32'h4100, {17'h0, o_lso, o_mss});
		cmp("tag_fcs", 32'h3, {30'h0, o_tag_ins, o_fcs_ins});
		cmp("vtag", 32'hABCD, {16'h0, o_vtag});
		cmp("txe", 32'h0, 32'(o_tx_err));
		tx_buf(32'h17C0_0004, 32'h0000_0001);
		cmp("cs", 32'hE, {28'h0, o_cs_icmp, o_cs_ip, o_cs_l4, o_cs_igmp});
		cmp("tag_rep", 32'h3, {30'h0, o_tag_ins, o_tag_rep});
		cmp("txe", 32'h0, 32'(o_tx_err));
		foreach (bad[i]) begin
			tx_buf(bad[i] | 32'h0040_0000, 32'h0);
			cmp("txe", 32'h1, 32'(o_tx_err));
			rd(OFF_INTERRUPT_STATUS_REG, 32'h2);
			wr(OFF_INTERRUPT_STATUS_REG, 32'h2);
			cmp("txe", 32'h0, 32'(o_tx_err));
		end
		print_verdict;
	end
endmodule
`default_nettype wire

/* sim/ufc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ufc_chk import ufc_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [REG_AW-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	// Streams and sideband
	input wire logic o_rx_ready,
	input wire logic o_rxo_valid,
	input wire logic o_fc_on,
	input wire logic o_fc_off,
	input wire logic o_pause_xoff,
	input wire logic o_pause_xon,
	input wire logic o_cs_igmp,
	input wire logic o_cs_icmp,
	input wire logic o_cs_ip,
	input wire logic o_cs_l4,
	input wire logic o_lso,
	input wire logic o_tag_ins,
	input wire logic o_tag_rep,
	input wire logic o_rx_dis_irq,
	input wire logic o_tx_err
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic flush_wr = i_wr && i_addr == OFF_RX_CTL && i_wdata[RXC_FLUSH_BIT];
	// Only these writes may touch a receive or interrupt enable or a disabled status
	wire logic irq_wr = i_wr && (i_addr == OFF_RX_CTL || i_addr == OFF_MAC_RECEIVE_REG || i_addr == OFF_INT_EN);
	wire logic txe_clr = i_wr && i_addr == OFF_INTERRUPT_STATUS_REG && i_wdata[INT_TXERR_BIT];
	// ****************************************
	// Assertions
	// ****************************************
	a_flush_blocks: assert property (flush_wr |=> !o_rx_ready && !o_rxo_valid)
		else $error("flush did not stall the receive streams");
	a_flush_empties: assert property (flush_wr |-> ##3 !o_rxo_valid)
		else $error("receive FIFO not empty after flush");
	a_irq_holds: assert property (o_rx_dis_irq && !irq_wr |=> o_rx_dis_irq)
		else $error("receive disabled interrupt dropped on its own");
	a_off_pulse: assert property (o_fc_off |=> !o_fc_off)
		else $error("flow off longer than one cycle");
	a_off_not_on: assert property (o_fc_off |-> !o_fc_on)
		else $error("flow off while flow on");
	a_xoff_with_on: assert property (o_pause_xoff |-> o_fc_on)
		else $error("pause request without flow on");
	a_xon_with_off: assert property (o_pause_xon |-> o_fc_off)
		else $error("zero pause without flow off");
	a_lso_masks_cs: assert property (o_lso |-> !(o_cs_igmp || o_cs_icmp || o_cs_ip || o_cs_l4))
		else $error("checksum request under segmentation offload");
	a_rep_needs_ins: assert property (o_tag_rep |-> o_tag_ins)
		else $error("tag replace without tag insert");
	a_txerr_sticky: assert property (o_tx_err && !txe_clr |=> o_tx_err)
		else $error("transmit error cleared without a write");
	c_xoff: cover property (o_pause_xoff);
	c_xon: cover property (o_pause_xon);
	c_txerr: cover property ($rose(o_tx_err));
	c_irq_clr: cover property ($fell(o_rx_dis_irq));
endmodule
bind ufc_fifo_ctl ufc_chk i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .o_rx_ready(o_rx_ready), .o_rxo_valid(o_rxo_valid), .o_fc_on(o_fc_on), .o_fc_off(o_fc_off),
	.o_pause_xoff(o_pause_xoff), .o_pause_xon(o_pause_xon), .o_cs_igmp(o_cs_igmp), .o_cs_icmp(o_cs_icmp),
	.o_cs_ip(o_cs_ip), .o_cs_l4(o_cs_l4), .o_lso(o_lso), .o_tag_ins(o_tag_ins), .o_tag_rep(o_tag_rep),
	.o_rx_dis_irq(o_rx_dis_irq), .o_tx_err(o_tx_err));
`default_nettype wire

/* sim/ufc_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ufc_mac_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Bench control
	input wire logic i_go,
	input wire logic i_slow,
	// Receive side
	input wire logic i_mac_receive_reg_en,
	input wire logic i_rx_ready,
	output logic o_rx_valid,
	output logic [31:0] o_rx_data,
	output logic o_busy,
	// Transmit read side
	output logic o_txf_ready
);
	logic [31:0] word_r;
	logic [2:0] cnt_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rx_valid <= 1'b0;
			word_r <= 32'h0;
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
			if (o_rx_valid && i_rx_ready)
				word_r <= word_r + 32'h01010101;
			// Offer held until taken, new words only while receiver enabled
			if (!o_rx_valid || i_rx_ready)
				o_rx_valid <= i_go && i_mac_receive_reg_en;
		end
	end
	// Idle bus shows garbage, not the last word
	assign o_rx_data = o_rx_valid ? word_r : ~word_r;
	assign o_busy = o_rx_valid;
	assign o_txf_ready = !i_slow || cnt_r[1:0] == 2'h3;
endmodule
`default_nettype wire
